// ---- pcg_top.sv ----
// Peripheral clock gating and timer 2 pin routing registers
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pcg_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [2:0] timer2_ch2_route,
   output logic [2:0] timer2_ch1_route,
   output logic [2:0] timer2_ch0_route,
   output logic analog_comparator_1_gclk,
   output logic analog_comparator_0_gclk,
   output logic converter_gclk,
   output logic ext_irq_gclk,
   output logic keypad_irq_1_gclk,
   output logic keypad_irq_0_gclk,
   output logic serial_port_2_gclk,
   output logic serial_port_1_gclk,
   output logic serial_port_0_gclk,
   output logic spi_ctrl_b_gclk,
   output logic spi_ctrl_a_gclk,
   output logic i2c_ctrl_b_gclk,
   output logic i2c_ctrl_a_gclk,
   output logic debug_port_gclk,
   output logic flash_gclk,
   output logic crc_gclk
);
   pcg_reg_if rif ();

   logic [31:0] route_reg;
   logic [31:0] route_next;
   logic [31:0] gate_reg;
   logic [31:0] gate_next;
   logic [31:0] route_merged;
   logic [15:0] gclk_vec;
   logic [15:0] en_q_vec;
   logic route_wr;
   logic gate_wr;

   // Byte-lane merge of write data under a writable mask
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0] strb,
      input logic [31:0] wmask
   );
      logic [31:0] lane_mask;
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      lane_merge = (old_val & ~(lane_mask & wmask)) | (new_val & lane_mask & wmask);
   endfunction

   // Field update that refuses the reserved code
   function automatic logic [1:0] route_pick(
      input logic [1:0] old_code,
      input logic [1:0] new_code
   );
      route_pick = (new_code == pcg_pkg::PCG_ROUTE_RESV) ? old_code : new_code;
   endfunction

   // One-hot pin select from a route code
   function automatic logic [2:0] route_onehot(
      input logic [1:0] code
   );
      case (code)
         pcg_pkg::PCG_ROUTE_ALT0: route_onehot = 3'h1;
         pcg_pkg::PCG_ROUTE_ALT1: route_onehot = 3'h2;
         pcg_pkg::PCG_ROUTE_ALT2: route_onehot = 3'h4;
         default: route_onehot = 3'h0;
      endcase
   endfunction

   // Bus front end
   pcg_apb_slave u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .pce(pce),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .rif(rif)
   );

   // Address decode and read mux
   assign route_wr = rif.wr_en && (rif.addr == pcg_pkg::ROUTE_OFFSET);
   assign gate_wr = rif.wr_en && (rif.addr == pcg_pkg::GATE_OFFSET);
   assign rif.hit = (rif.addr == pcg_pkg::ROUTE_OFFSET) || (rif.addr == pcg_pkg::GATE_OFFSET);

   always_comb begin
      if (rif.addr == pcg_pkg::ROUTE_OFFSET) begin
         rif.rdata = route_reg & pcg_pkg::ROUTE_WMASK;
      end else if (rif.addr == pcg_pkg::GATE_OFFSET) begin
         rif.rdata = gate_reg & pcg_pkg::GATE_WMASK;
      end else begin
         rif.rdata = 32'h0000_0000;
      end
   end

   // Next route value, reserved codes keep the old field
   always_comb begin
      route_merged = lane_merge(route_reg, rif.wdata, rif.wstrb, pcg_pkg::ROUTE_WMASK);
      route_next = route_merged;
      route_next[pcg_pkg::ROUTE_CH2_LSB +: pcg_pkg::ROUTE_W] =
         route_pick(route_reg[pcg_pkg::ROUTE_CH2_LSB +: pcg_pkg::ROUTE_W],
                    route_merged[pcg_pkg::ROUTE_CH2_LSB +: pcg_pkg::ROUTE_W]);
      route_next[pcg_pkg::ROUTE_CH1_LSB +: pcg_pkg::ROUTE_W] =
         route_pick(route_reg[pcg_pkg::ROUTE_CH1_LSB +: pcg_pkg::ROUTE_W],
                    route_merged[pcg_pkg::ROUTE_CH1_LSB +: pcg_pkg::ROUTE_W]);
      route_next[pcg_pkg::ROUTE_CH0_LSB +: pcg_pkg::ROUTE_W] =
         route_pick(route_reg[pcg_pkg::ROUTE_CH0_LSB +: pcg_pkg::ROUTE_W],
                    route_merged[pcg_pkg::ROUTE_CH0_LSB +: pcg_pkg::ROUTE_W]);
   end

   // Next gate value, reserved bits never stored
   assign gate_next = lane_merge(gate_reg, rif.wdata, rif.wstrb, pcg_pkg::GATE_WMASK);

   // Route register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_reg <= pcg_pkg::ROUTE_RESET;
      end else if (pce && route_wr) begin
         route_reg <= route_next;
      end
   end

   // Gate register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_reg <= pcg_pkg::GATE_RESET;
      end else if (pce && gate_wr) begin
         gate_reg <= gate_next;
      end
   end

   // Registered one-hot pin selects for timer 2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer2_ch2_route <= route_onehot(pcg_pkg::ROUTE_RESET[5:4]);
         timer2_ch1_route <= route_onehot(pcg_pkg::ROUTE_RESET[3:2]);
         timer2_ch0_route <= route_onehot(pcg_pkg::ROUTE_RESET[1:0]);
      end else if (pce) begin
         timer2_ch2_route <= route_onehot(route_reg[pcg_pkg::ROUTE_CH2_LSB +: pcg_pkg::ROUTE_W]);
         timer2_ch1_route <= route_onehot(route_reg[pcg_pkg::ROUTE_CH1_LSB +: pcg_pkg::ROUTE_W]);
         timer2_ch0_route <= route_onehot(route_reg[pcg_pkg::ROUTE_CH0_LSB +: pcg_pkg::ROUTE_W]);
      end
   end

   // One glitch-free gate per peripheral
   for (genvar gi = 0; gi < pcg_pkg::GATE_N; gi++) begin : g_gate
      pcg_clk_gate #(
         .RST_VAL(pcg_pkg::GATE_RESET[pcg_pkg::GATE_POS[gi]])
      ) u_gate (
         .clk(pclk),
         .rst_n(presetn),
         .ce(pce),
         .en(gate_reg[pcg_pkg::GATE_POS[gi]]),
         .en_q(en_q_vec[gi]),
         .gclk(gclk_vec[gi])
      );

      // Gate enable tracks its register bit
      a_gate_follows_bit: assert property (
         @(posedge pclk) disable iff (!presetn)
         pce |-> (en_q_vec[gi] == gate_reg[pcg_pkg::GATE_POS[gi]]))
         else $error("clock gate enable does not follow its register bit");

      // Gated clock carries its enable through the whole high phase
      a_gclk_high_phase: assert property (
         @(negedge pclk) disable iff (!presetn)
         gclk_vec[gi] == en_q_vec[gi])
         else $error("gated clock high phase does not match its enable");
   end

   // Named gated clocks
   assign analog_comparator_1_gclk = gclk_vec[pcg_pkg::GI_ANA_CMP1];
   assign analog_comparator_0_gclk = gclk_vec[pcg_pkg::GI_ANA_CMP0];
   assign converter_gclk = gclk_vec[pcg_pkg::GI_ADC];
   assign ext_irq_gclk = gclk_vec[pcg_pkg::GI_EXTIRQ];
   assign keypad_irq_1_gclk = gclk_vec[pcg_pkg::GI_KEYPAD1];
   assign keypad_irq_0_gclk = gclk_vec[pcg_pkg::GI_KEYPAD0];
   assign serial_port_2_gclk = gclk_vec[pcg_pkg::GI_SERIAL2];
   assign serial_port_1_gclk = gclk_vec[pcg_pkg::GI_SERIAL1];
   assign serial_port_0_gclk = gclk_vec[pcg_pkg::GI_SERIAL0];
   assign spi_ctrl_b_gclk = gclk_vec[pcg_pkg::GI_SPI_B];
   assign spi_ctrl_a_gclk = gclk_vec[pcg_pkg::GI_SPI_A];
   assign i2c_ctrl_b_gclk = gclk_vec[pcg_pkg::GI_I2C_B];
   assign i2c_ctrl_a_gclk = gclk_vec[pcg_pkg::GI_I2C_A];
   assign debug_port_gclk = gclk_vec[pcg_pkg::GI_DEBUG];
   assign flash_gclk = gclk_vec[pcg_pkg::GI_FLASH];
   assign crc_gclk = gclk_vec[pcg_pkg::GI_CRC];

   // Channel 2 select tracks its field one cycle later
   a_route2_decode: assert property (
      @(posedge pclk) disable iff (!presetn)
      pce |=> (timer2_ch2_route == (($past(route_reg[5:4]) == 2'h0) ? 3'h1 :
                                    ($past(route_reg[5:4]) == 2'h1) ? 3'h2 : 3'h4)))
      else $error("channel 2 pin select does not match its field");

   // Channel 1 select tracks its field one cycle later
   a_route1_decode: assert property (
      @(posedge pclk) disable iff (!presetn)
      pce |=> (timer2_ch1_route == (($past(route_reg[3:2]) == 2'h0) ? 3'h1 :
                                    ($past(route_reg[3:2]) == 2'h1) ? 3'h2 : 3'h4)))
      else $error("channel 1 pin select does not match its field");

   // Channel 0 select tracks its field one cycle later
   a_route0_decode: assert property (
      @(posedge pclk) disable iff (!presetn)
      pce |=> (timer2_ch0_route == (($past(route_reg[1:0]) == 2'h0) ? 3'h1 :
                                    ($past(route_reg[1:0]) == 2'h1) ? 3'h2 : 3'h4)))
      else $error("channel 0 pin select does not match its field");

   // No route field ever holds the reserved code
   a_route_no_resv: assert property (
      @(posedge pclk) disable iff (!presetn)
      (route_reg[5:4] != 2'h3) && (route_reg[3:2] != 2'h3) && (route_reg[1:0] != 2'h3))
      else $error("route field holds the reserved code");

   // A full write of channel 2 field lands next cycle
   a_route2_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && route_wr && rif.wstrb[0] && (rif.wdata[5:4] != 2'h3))
      |=> (route_reg[5:4] == $past(rif.wdata[5:4])))
      else $error("channel 2 field write lost");

   // Reserved gate bits and unmodelled low bits stay zero
   a_gate_resv_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (gate_reg & ~pcg_pkg::GATE_WMASK) == 32'h0000_0000)
      else $error("reserved gate bit became set");

   // Reading the gate register returns its value with reserved bits zero
   a_gate_readback: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && psel && !penable && !pwrite && (paddr == pcg_pkg::GATE_OFFSET) && !pready)
      |=> (pready && (prdata == ($past(gate_reg) & 32'hEB7F_3400))))
      else $error("gate register read returned a wrong value");

   // CRC gate write shows at the gate within one cycle
   a_crc_gate_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && gate_wr && rif.wstrb[1]) ##1 pce
      |-> (en_q_vec[pcg_pkg::GI_CRC] == $past(rif.wdata[10])))
      else $error("CRC gate did not take the written value");

   // Setup cycle is answered in the next cycle
   a_apb_answer: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && psel && !penable && !pready) |=> pready)
      else $error("bus setup not answered in one cycle");

   // Unmapped address gives an error answer
   a_apb_unmapped: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && psel && !penable && !pready && (paddr != pcg_pkg::ROUTE_OFFSET) && (paddr != pcg_pkg::GATE_OFFSET))
      |=> (pslverr && (prdata == 32'h0000_0000)))
      else $error("unmapped access not flagged");

   // Gate register holds while no write to it
   a_gate_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !gate_wr |=> $stable(gate_reg))
      else $error("gate register changed without a write");

   // Route register holds while no write to it
   a_route_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !route_wr |=> $stable(route_reg))
      else $error("route register changed without a write");

   // Reserved code written to channel 2 keeps the old field
   a_route2_resv_keep: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && route_wr && rif.wstrb[0] && (rif.wdata[5:4] == 2'h3)) |=> $stable(route_reg[5:4]))
      else $error("channel 2 field took the reserved code");

   // Reserved code written to channel 1 keeps the old field
   a_route1_resv_keep: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && route_wr && rif.wstrb[0] && (rif.wdata[3:2] == 2'h3)) |=> $stable(route_reg[3:2]))
      else $error("channel 1 field took the reserved code");

   // Reserved code written to channel 0 keeps the old field
   a_route0_resv_keep: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && route_wr && rif.wstrb[0] && (rif.wdata[1:0] == 2'h3)) |=> $stable(route_reg[1:0]))
      else $error("channel 0 field took the reserved code");

   // Full-word gate write stores every gate bit, reserved bits dropped
   a_gate_full_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && gate_wr && (rif.wstrb == 4'hF)) |=> (gate_reg == ($past(rif.wdata) & pcg_pkg::GATE_WMASK)))
      else $error("gate register full write lost");

   // Reading the route register returns its fields
   a_route_readback: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && psel && !penable && !pwrite && (paddr == pcg_pkg::ROUTE_OFFSET) && !pready)
      |=> (pready && (prdata == ($past(route_reg) & pcg_pkg::ROUTE_WMASK))))
      else $error("route register read returned a wrong value");

   // Answer lasts exactly one access cycle
   a_apb_release: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pce && psel && penable && pready) |=> !pready)
      else $error("bus answer did not end after completion");

   // Error and read data only beside an answer
   a_answer_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      !pready |-> (!pslverr && (prdata == 32'h0000_0000)))
      else $error("bus error or data shown without an answer");

   // Clock enable low freezes registers and the answer
   a_ce_freeze: assert property (
      @(posedge pclk) disable iff (!presetn)
      !pce |=> ($stable(route_reg) && $stable(gate_reg) && $stable(pready)))
      else $error("state moved while the clock enable was low");

   // Register writes only at the completing edge
   a_write_at_done: assert property (
      @(posedge pclk) disable iff (!presetn)
      rif.wr_en |-> (psel && penable && pready))
      else $error("register write outside a completing transfer");
endmodule

// ---- pcg_pkg.sv ----
// Constants and types for the peripheral clock gating and pin routing block
// How it works
// - Timer 2 channel 2 route at bits 5:4: port C2, D0, G4; 11 reserved.
// - Timer 2 channel 1 route at bits 3:2: port C1, H1, F1; 11 reserved.
// - Timer 2 channel 0 route at bits 1:0: port C0, H0, F0; 11 reserved.
// - Gate bit 31 passes the bus clock to analog comparator 1.
// - Gate bit 30 passes the bus clock to analog comparator 0.
// - Gate bit 29 passes the bus clock to the converter.
// - Gate bit 27 passes the bus clock to the external interrupt module.
// - Gate bits 25 and 24 pass clocks to keyboard interrupt units 1 and 0.
// - Gate bit 22 passes the bus clock to serial port 2.
// - Gate bit 21 passes the bus clock to serial port 1.
// - Gate bit 20 passes the bus clock to serial port 0.
// - Gate bits 19 and 18 pass clocks to SPI controllers 1 and 0.
// - Gate bits 17 and 16 pass clocks to I2C controllers 1 and 0.
// - Gate bit 13 passes the bus clock to the debug port.
// - Gate bit 12 passes the bus clock to the flash block.
// - Gate bit 10 controls the CRC unit clock.
// - CRC gate 0 stops the CRC clock, 1 passes it.
// - Gate bits 28, 26, 23, 15:14 and 11 are reserved, read zero.
package pcg_pkg;
   // Bus widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   // Register byte offsets
   localparam logic [11:0] ROUTE_OFFSET = 12'h010;
   localparam logic [11:0] GATE_OFFSET = 12'h014;
   // Route field positions and width
   localparam int ROUTE_W = 2;
   localparam int ROUTE_CH2_LSB = 4;
   localparam int ROUTE_CH1_LSB = 2;
   localparam int ROUTE_CH0_LSB = 0;
   // Reset values and writable masks
   localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
   localparam logic [31:0] ROUTE_WMASK = 32'h0000_003F;
   localparam logic [31:0] GATE_RESET = 32'h0000_3000;
   localparam logic [31:0] GATE_WMASK = 32'hEB7F_3400;
   // Route codes of a two-bit select field
   typedef enum logic [1:0] {
      PCG_ROUTE_ALT0 = 2'h0,
      PCG_ROUTE_ALT1 = 2'h1,
      PCG_ROUTE_ALT2 = 2'h2,
      PCG_ROUTE_RESV = 2'h3
   } pcg_route_t;
   // Bus slave states
   typedef enum logic [1:0] {
      PCG_IDLE = 2'b01,
      PCG_ACCESS = 2'b10
   } pcg_state_t;
   // Gate count, gate vector index and its register bit
   localparam int GATE_N = 16;
   localparam int GI_ANA_CMP1 = 0;
   localparam int GI_ANA_CMP0 = 1;
   localparam int GI_ADC = 2;
   localparam int GI_EXTIRQ = 3;
   localparam int GI_KEYPAD1 = 4;
   localparam int GI_KEYPAD0 = 5;
   localparam int GI_SERIAL2 = 6;
   localparam int GI_SERIAL1 = 7;
   localparam int GI_SERIAL0 = 8;
   localparam int GI_SPI_B = 9;
   localparam int GI_SPI_A = 10;
   localparam int GI_I2C_B = 11;
   localparam int GI_I2C_A = 12;
   localparam int GI_DEBUG = 13;
   localparam int GI_FLASH = 14;
   localparam int GI_CRC = 15;
   localparam int GATE_POS [GATE_N] = '{31, 30, 29, 27, 25, 24, 22, 21, 20, 19, 18, 17, 16, 13, 12, 10};
endpackage

// ---- pcg_reg_if.sv ----
// Register access carrier between the bus slave and the register file
`timescale 1ns/1ps
interface pcg_reg_if;
   logic wr_en;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic [31:0] rdata;
   logic hit;
   modport bus (output wr_en, output addr, output wdata, output wstrb, input rdata, input hit);
   modport regs (input wr_en, input addr, input wdata, input wstrb, output rdata, output hit);
endinterface

// ---- pcg_clk_gate.sv ----
// Glitch-free clock gate with enable retimed on the falling edge
`timescale 1ns/1ps
module pcg_clk_gate #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic en,
   output logic en_q,
   output logic gclk
);
   // Enable changes only while the clock is low
   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= RST_VAL;
      end else if (ce) begin
         en_q <= en;
      end
   end

   // Clock passes only with a stable enable
   assign gclk = clk & en_q;
endmodule

// ---- pcg_apb_slave.sv ----
// APB slave front end, zero wait state, registered answers
`timescale 1ns/1ps
module pcg_apb_slave (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   pcg_reg_if.bus rif
);
   pcg_pkg::pcg_state_t state_reg;
   logic setup;
   logic done;

   // Phase detection
   assign setup = (state_reg == pcg_pkg::PCG_IDLE) && psel && !penable;
   assign done = (state_reg == pcg_pkg::PCG_ACCESS) && psel && penable;

   // Request to the register file
   assign rif.addr = paddr;
   assign rif.wdata = pwdata;
   assign rif.wstrb = pstrb;
   assign rif.wr_en = pce && done && pwrite && rif.hit;

   // Transfer phase tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= pcg_pkg::PCG_IDLE;
      end else if (pce) begin
         case (state_reg)
            pcg_pkg::PCG_IDLE: begin
               if (setup) begin
                  state_reg <= pcg_pkg::PCG_ACCESS;
               end
            end
            pcg_pkg::PCG_ACCESS: begin
               if (done) begin
                  state_reg <= pcg_pkg::PCG_IDLE;
               end
            end
            default: begin
               state_reg <= pcg_pkg::PCG_IDLE;
            end
         endcase
      end
   end

   // Answer captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (pce) begin
         if (setup) begin
            pready <= 1'b1;
            pslverr <= !rif.hit;
            prdata <= (!pwrite && rif.hit) ? rif.rdata : 32'h0000_0000;
         end else if (done) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
         end
      end
   end
endmodule

// ---- pcg_top_tb.sv ----
// Self-checking bench for the clock gating and timer 2 pin routing block
`timescale 1ns/1ps
module pcg_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic pce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   wire logic [31:0] prdata;
   wire logic pready;
   wire logic pslverr;
   wire logic [2:0] route_ch2;
   wire logic [2:0] route_ch1;
   wire logic [2:0] route_ch0;
   wire logic [15:0] gv;
   int failures = 0;
   int n_checks = 0;
   logic [33:0] exp_q [$];
   logic [33:0] e;
   logic [31:0] rnd = 32'h0001_7C64;
   logic [31:0] gate_m;
   logic [31:0] route_m;
   logic [11:0] bad_addr [3] = '{12'h000, 12'h018, 12'hFFC};

   pcg_top pcg_top_inst (
      .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer2_ch2_route(route_ch2), .timer2_ch1_route(route_ch1), .timer2_ch0_route(route_ch0),
      .analog_comparator_1_gclk(gv[0]), .analog_comparator_0_gclk(gv[1]), .converter_gclk(gv[2]),
      .ext_irq_gclk(gv[3]), .keypad_irq_1_gclk(gv[4]), .keypad_irq_0_gclk(gv[5]),
      .serial_port_2_gclk(gv[6]), .serial_port_1_gclk(gv[7]), .serial_port_0_gclk(gv[8]),
      .spi_ctrl_b_gclk(gv[9]), .spi_ctrl_a_gclk(gv[10]), .i2c_ctrl_b_gclk(gv[11]),
      .i2c_ctrl_a_gclk(gv[12]), .debug_port_gclk(gv[13]), .flash_gclk(gv[14]), .crc_gclk(gv[15])
   );

   // Bus clock, 50 ns period
   always #25 pclk = ~pclk;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Byte lanes limited to writable bits
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s,
                                         input logic [31:0] m);
      logic [31:0] k;
      for (int i = 0; i < 4; i++) k[8*i +: 8] = {8{s[i]}};
      k = k & m;
      return (o & ~k) | (d & k);
   endfunction

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic end_sim;
      if (failures == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // APB master: setup, optional clock-enable stall, access held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [31:0] exp, input logic err, input int stall);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      if (stall > 0) pce <= 1'b0;
      exp_q.push_back({~w, err, exp});
      repeat (stall) begin
         @(posedge pclk);
         cmp_bit(pready, 1'b0, "pready while stalled");
      end
      if (stall > 0) pce <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) cmp_bit(1'b0, 1'b1, "no pready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic mapped(input logic [11:0] a);
      return a == pcg_pkg::ROUTE_OFFSET || a == pcg_pkg::GATE_OFFSET;
   endfunction

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input int stall);
      logic [31:0] r;
      apb(1'b1, a, d, s, 32'h0000_0000, ~mapped(a), stall);
      if (a == pcg_pkg::GATE_OFFSET) gate_m = merge(gate_m, d, s, pcg_pkg::GATE_WMASK);
      if (a == pcg_pkg::ROUTE_OFFSET) begin
         r = merge(route_m, d, s, pcg_pkg::ROUTE_WMASK);
         for (int f = 0; f < 3; f++) if (r[2*f +: 2] == 2'h3) r[2*f +: 2] = route_m[2*f +: 2];
         route_m = r;
      end
   endtask

   task automatic rd(input logic [11:0] a);
      logic [31:0] x;
      x = (a == pcg_pkg::ROUTE_OFFSET) ? route_m : (a == pcg_pkg::GATE_OFFSET) ? gate_m : 32'h0000_0000;
      apb(1'b0, a, 32'h0000_0000, 4'h0, x, ~mapped(a), 0);
   endtask

   // Route outputs and gated clocks, in high and low phase
   task automatic check_out;
      repeat (2) @(posedge pclk);
      #10;
      cmp_word({29'h0, route_ch2}, 32'h1 << route_m[5:4], "ch2 route");
      cmp_word({29'h0, route_ch1}, 32'h1 << route_m[3:2], "ch1 route");
      cmp_word({29'h0, route_ch0}, 32'h1 << route_m[1:0], "ch0 route");
      for (int i = 0; i < 16; i++) begin
         cmp_bit(gv[i], gate_m[pcg_pkg::GATE_POS[i]], "gclk high phase");
      end
      #20;
      for (int i = 0; i < 16; i++) cmp_bit(gv[i], 1'b0, "gclk low phase");
   endtask

   // Result watcher: oldest note against each completed transfer
   always @(posedge pclk) begin
      if (presetn && psel && penable && pce && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp_bit(1'b0, 1'b1, "unexpected transfer");
         end else begin
            e = exp_q.pop_front();
            cmp_bit(pslverr, e[32], "pslverr");
            if (e[33]) cmp_word(prdata, e[31:0], "prdata");
         end
      end
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      cmp_bit(1'b0, 1'b1, "watchdog");
      end_sim;
   end

   initial begin
      gate_m = pcg_pkg::GATE_RESET;
      route_m = pcg_pkg::ROUTE_RESET;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      check_out;
      rd(pcg_pkg::ROUTE_OFFSET);
      rd(pcg_pkg::GATE_OFFSET);
      // Every code on every channel, reserved code last
      for (int ch = 0; ch < 3; ch++) begin
         for (int c = 0; c < 4; c++) begin
            wr(pcg_pkg::ROUTE_OFFSET, (route_m & ~(32'h3 << 2*ch)) | (32'(c) << 2*ch), 4'hF, 0);
            check_out;
            rd(pcg_pkg::ROUTE_OFFSET);
         end
      end
      // All gates on, all off, then random data and strobes
      wr(pcg_pkg::GATE_OFFSET, 32'hFFFF_FFFF, 4'hF, 0);
      check_out;
      rd(pcg_pkg::GATE_OFFSET);
      wr(pcg_pkg::GATE_OFFSET, 32'h0000_0000, 4'hF, 3);
      check_out;
      rd(pcg_pkg::GATE_OFFSET);
      repeat (10) begin
         rnd = lfsr(rnd);
         wr(pcg_pkg::GATE_OFFSET, rnd, rnd[7:4] | 4'h1, 0);
         rnd = lfsr(rnd);
         wr(pcg_pkg::ROUTE_OFFSET, rnd, rnd[31:28], 0);
         check_out;
         rd(pcg_pkg::GATE_OFFSET);
         rd(pcg_pkg::ROUTE_OFFSET);
      end
      // Unmapped places refuse and change nothing
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         wr(bad_addr[i], rnd, 4'hF, 0);
         rd(bad_addr[i]);
      end
      rd(pcg_pkg::GATE_OFFSET);
      rd(pcg_pkg::ROUTE_OFFSET);
      // Second reset in mid-run
      wr(pcg_pkg::GATE_OFFSET, 32'h1234_5678, 4'hF, 0);
      @(posedge pclk);
      presetn <= 1'b0;
      gate_m = pcg_pkg::GATE_RESET;
      route_m = pcg_pkg::ROUTE_RESET;
      check_out;
      cmp_word(prdata, 32'h0000_0000, "prdata in reset");
      cmp_bit(pready, 1'b0, "pready in reset");
      @(posedge pclk);
      presetn <= 1'b1;
      rd(pcg_pkg::GATE_OFFSET);
      rd(pcg_pkg::ROUTE_OFFSET);
      check_out;
      cmp_word(32'(exp_q.size()), 32'h0000_0000, "pending transfers");
      end_sim;
   end
endmodule
